/* File: logic/cmb_top.sv */
`timescale 1ns/1ps
module cmb_top #(
  parameter int NBUF = cmb_pkg::TX_BUFS
) (
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  input  wire logic [cmb_pkg::AW-1:0] addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [7:0]             rdata,
  input  wire logic                   can_rx,
  output logic                        can_tx,
  input  wire cmb_pkg::cmb_rx_in_type rx_in,
  input  wire cmb_pkg::cmb_tx_in_type tx_in,
  output cmb_pkg::cmb_eng_out_type    eng_out,
  output logic                        irq_rx,
  output logic                        irq_tx,
  output logic                        irq_err
);
  import cmb_pkg::*;

  // elaboration checks: buffer count fits the two-bit index
  if (NBUF < 1 || NBUF > 3) begin : g_bad_nbuf
    $error("NBUF must be 1 to 3");
  end
  // the priority byte must sit past the frame bytes in each 16-byte window
  if (NBYTES > 16 || int'(LOCAL_PRIORITY_FIELD_OFS) < NBYTES) begin : g_bad_layout
    $error("buffer layout does not fit a 16-byte window");
  end

  ////////////////////////////////////////////////////////////////////
  // state
  logic [2:0]      rx_sync_ff, nxt_rx_sync;
  logic            rx_level_ff, nxt_rx_level;
  logic            can_tx_ff, nxt_can_tx;
  logic            ack_en_ff, nxt_ack_en;
  logic [7:0]      bg_ff [NBYTES];
  logic [7:0]      nxt_bg [NBYTES];
  logic [7:0]      fg_ff [NBYTES];
  logic [7:0]      nxt_fg [NBYTES];

  // transmit buffers and their priority bytes
  logic [7:0]      txb_ff [NBUF][NBYTES];
  logic [7:0]      nxt_txb [NBUF][NBYTES];
  logic [7:0]      local_priority_field_ff [NBUF];
  logic [7:0]      nxt_local_priority_field [NBUF];

  // receive and transmit status flags, software controls
  logic            rx_full_ff, nxt_rx_full;
  logic            bg_full_ff, nxt_bg_full;
  logic            ovr_ff, nxt_ovr;
  logic [NBUF-1:0] txe_ff, nxt_txe;
  logic [NBUF-1:0] abort_acknowledge_bit_ff, nxt_abort_acknowledge_bit;
  logic [NBUF-1:0] abrq_ff, nxt_abrq;
  logic [NBUF-1:0] txie_ff, nxt_txie;
  logic            loop_ff, nxt_loop;
  logic            rxie_ff, nxt_rxie;
  logic            ovrie_ff, nxt_ovrie;

  // scheduling state, engine and host outputs
  logic            tx_active_ff, nxt_tx_active;
  logic [1:0]      act_idx_ff, nxt_act_idx;
  logic            sel_valid_ff, nxt_sel_valid;
  logic [1:0]      sel_idx_ff, nxt_sel_idx;
  logic [7:0]      tx_byte_ff, nxt_tx_byte;
  logic [7:0]      rdata_ff, nxt_rdata;
  logic            irq_rx_ff, nxt_irq_rx;
  logic            irq_tx_ff, nxt_irq_tx;
  logic            irq_err_ff, nxt_irq_err;

  ////////////////////////////////////////////////////////////////////
  // address decode of the transmit windows
  logic [3:0] hi_nib;
  logic [3:0] lo_nib;
  logic       tb_hit;
  logic [1:0] tb_idx;
  logic [3:0] tb_sub;
  logic [2:0] txe3;
  logic [2:0] abtak3;
  logic [2:0] abrq3;
  logic [2:0] txie3;

  assign hi_nib = addr[7:4];
  assign lo_nib = addr[3:0];
  assign tb_hit = (hi_nib >= 4'h1) && (hi_nib <= 4'(NBUF));
  assign tb_sub = hi_nib - 4'h1;
  assign tb_idx = tb_sub[1:0];
  assign txe3   = 3'(txe_ff);
  assign abtak3 = 3'(abort_acknowledge_bit_ff);
  assign abrq3  = 3'(abrq_ff);
  assign txie3  = 3'(txie_ff);

  ////////////////////////////////////////////////////////////////////
  // pin synchroniser and tx pin level
  always_comb begin
    nxt_rx_sync  = {rx_sync_ff[1:0], can_rx};
    nxt_rx_level = rx_level_ff;
    if (rx_sync_ff[1] == rx_sync_ff[2]) begin
      nxt_rx_level = rx_sync_ff[2];
    end
    nxt_can_tx = tx_in.dom ? DOMINANT : RECESSIVE;
    nxt_ack_en = ~(tx_active_ff & ~loop_ff);
  end

  ////////////////////////////////////////////////////////////////////
  // registers, receive path, transmit scheduling, read mux
  always_comb begin
    logic            clr_full;
    logic            clr_ovr;
    logic [NBUF-1:0] clr_txe;
    logic            accept;
    logic            found;
    logic [1:0]      best_idx;
    logic [7:0]      best_local_priority_field;
    clr_full  = 1'b0;
    clr_ovr   = 1'b0;
    clr_txe   = '0;
    accept    = 1'b0;
    found     = 1'b0;
    best_idx  = 2'b00;
    best_local_priority_field = 8'hFF;

    nxt_bg        = bg_ff;
    nxt_fg        = fg_ff;
    nxt_txb       = txb_ff;
    nxt_local_priority_field      = local_priority_field_ff;
    nxt_rx_full   = rx_full_ff;
    nxt_bg_full   = bg_full_ff;
    nxt_ovr       = ovr_ff;
    nxt_txe       = txe_ff;
    nxt_abort_acknowledge_bit     = abort_acknowledge_bit_ff;
    nxt_abrq      = abrq_ff;
    nxt_txie      = txie_ff;
    nxt_loop      = loop_ff;
    nxt_rxie      = rxie_ff;
    nxt_ovrie     = ovrie_ff;
    nxt_tx_active = tx_active_ff;
    nxt_act_idx   = act_idx_ff;
    nxt_sel_valid = sel_valid_ff;
    nxt_sel_idx   = sel_idx_ff;
    nxt_rdata     = BYTE_RST;

    // software writes: buffers, controls, abort requests
    if (wr) begin
      if (tb_hit && lo_nib < 4'(NBYTES)) begin
        nxt_txb[tb_idx][lo_nib] = wdata;
      end
      if (tb_hit && lo_nib == LOCAL_PRIORITY_FIELD_OFS) begin
        nxt_local_priority_field[tb_idx] = wdata;
      end
      if (addr == MCTL_ADR) begin
        nxt_loop  = wdata[MC_LOOP];
        nxt_rxie  = wdata[MC_RXIE];
        nxt_ovrie = wdata[MC_OVRIE];
      end
      if (addr == TXIE_ADR) begin
        nxt_txie = wdata[NBUF-1:0];
      end
      if (addr == TCTL_ADR) begin
        nxt_abrq = abrq_ff | wdata[NBUF-1:0];
      end
      if (addr == RFLAG_ADR) begin
        clr_full = wdata[RF_FULL];
        clr_ovr  = wdata[RF_OVR];
      end
      if (addr == TFLAG_ADR) begin
        clr_txe = wdata[NBUF-1:0];
      end
    end

    // background always takes the stream unless both stages hold frames
    if (rx_in.wr && !bg_full_ff && rx_in.idx < 4'(NBYTES)) begin
      nxt_bg[rx_in.idx] = rx_in.data;
    end

    // clearing full hands a pending background frame straight over
    if (clr_full && rx_full_ff) begin
      if (bg_full_ff) begin
        nxt_fg      = bg_ff;
        nxt_bg_full = 1'b0;
      end else begin
        nxt_rx_full = 1'b0;
      end
    end
    if (clr_ovr) begin
      nxt_ovr = 1'b0;
    end

    // frame end: own frames stay in background unless looped back
    accept = rx_in.done & rx_in.ok & rx_in.hit & (~tx_active_ff | loop_ff);
    if (accept) begin
      if (bg_full_ff) begin
        nxt_ovr = 1'b1;
      end else if (!nxt_rx_full || (clr_full && rx_full_ff)) begin
        nxt_fg      = nxt_bg;
        nxt_rx_full = 1'b1;
      end else begin
        nxt_bg_full = 1'b1;
      end
    end

    // software scheduling clears empty and the stale acknowledge
    for (int i = 0; i < NBUF; i++) begin
      if (clr_txe[i] && txe_ff[i]) begin
        nxt_txe[i]   = 1'b0;
        nxt_abort_acknowledge_bit[i] = 1'b0;
      end
    end

    // arbitration entry: pick lowest priority value, lowest index on tie
    if (tx_in.arb) begin
      for (int i = 0; i < NBUF; i++) begin
        if (!txe_ff[i] && !abrq_ff[i] && (!found || local_priority_field_ff[i] < best_local_priority_field)) begin
          found     = 1'b1;
          best_idx  = 2'(i);
          best_local_priority_field = local_priority_field_ff[i];
        end
      end
      nxt_sel_valid = found;
      nxt_sel_idx   = best_idx;
      nxt_tx_active = found;
      nxt_act_idx   = best_idx;
    end

    // frame on the bus finished well: release buffer as sent
    if (tx_in.done && tx_active_ff) begin
      nxt_txe[act_idx_ff]   = 1'b1;
      nxt_abort_acknowledge_bit[act_idx_ff] = 1'b0;
      nxt_abrq[act_idx_ff]  = 1'b0;
      nxt_tx_active         = 1'b0;
      nxt_sel_valid         = 1'b0;
    end
    // error or lost arbitration: buffer stays scheduled for a retry
    if (tx_in.fail) begin
      nxt_tx_active = 1'b0;
      nxt_sel_valid = 1'b0;
    end

    // abort grant only for buffers not on the bus
    for (int i = 0; i < NBUF; i++) begin
      if (abrq_ff[i] && !(tx_active_ff && act_idx_ff == 2'(i))) begin
        nxt_abrq[i] = 1'b0;
        if (!txe_ff[i]) begin
          nxt_txe[i]   = 1'b1;
          nxt_abort_acknowledge_bit[i] = 1'b1;
        end
      end
    end

    // read data for the cycle after the strobe
    if (rd) begin
      if (addr < AW'(NBYTES)) begin
        nxt_rdata = fg_ff[lo_nib];
      end else if (tb_hit && lo_nib < 4'(NBYTES)) begin
        nxt_rdata = txb_ff[tb_idx][lo_nib];
      end else if (tb_hit && lo_nib == LOCAL_PRIORITY_FIELD_OFS) begin
        nxt_rdata = local_priority_field_ff[tb_idx];
      end else if (addr == RFLAG_ADR) begin
        nxt_rdata = {5'h00, bg_full_ff, ovr_ff, rx_full_ff};
      end else if (addr == TFLAG_ADR) begin
        nxt_rdata = {1'b0, abtak3, 1'b0, txe3};
      end else if (addr == TCTL_ADR) begin
        nxt_rdata = {5'h00, abrq3};
      end else if (addr == MCTL_ADR) begin
        nxt_rdata = {5'h00, ovrie_ff, rxie_ff, loop_ff};
      end else if (addr == TXIE_ADR) begin
        nxt_rdata = {5'h00, txie3};
      end
    end

    // masked interrupt levels
    nxt_irq_rx  = rx_full_ff & rxie_ff;
    nxt_irq_tx  = |(txe_ff & txie_ff);
    nxt_irq_err = ovr_ff & ovrie_ff;
  end

  // byte fetch for the engine from the selected buffer
  always_comb begin
    nxt_tx_byte = BYTE_RST;
    if (tx_in.rd_idx < 4'(NBYTES)) begin
      nxt_tx_byte = txb_ff[sel_idx_ff][tx_in.rd_idx];
    end else if (tx_in.rd_idx == LOCAL_PRIORITY_FIELD_OFS) begin
      nxt_tx_byte = local_priority_field_ff[sel_idx_ff];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register all state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_sync_ff   <= 3'h7;
      rx_level_ff  <= RECESSIVE;
      can_tx_ff    <= RECESSIVE;
      ack_en_ff    <= 1'b1;
      for (int j = 0; j < NBYTES; j++) begin
        bg_ff[j] <= BYTE_RST;
        fg_ff[j] <= BYTE_RST;
        for (int i = 0; i < NBUF; i++) begin
          txb_ff[i][j] <= BYTE_RST;
        end
      end
      for (int i = 0; i < NBUF; i++) begin
        local_priority_field_ff[i] <= BYTE_RST;
      end
      rx_full_ff   <= 1'b0;
      bg_full_ff   <= 1'b0;
      ovr_ff       <= 1'b0;
      txe_ff       <= '1;
      abort_acknowledge_bit_ff     <= '0;
      abrq_ff      <= '0;
      txie_ff      <= '0;
      loop_ff      <= 1'b0;
      rxie_ff      <= 1'b0;
      ovrie_ff     <= 1'b0;
      tx_active_ff <= 1'b0;
      act_idx_ff   <= 2'b00;
      sel_valid_ff <= 1'b0;
      sel_idx_ff   <= 2'b00;
      tx_byte_ff   <= BYTE_RST;
      rdata_ff     <= BYTE_RST;
      irq_rx_ff    <= 1'b0;
      irq_tx_ff    <= 1'b0;
      irq_err_ff   <= 1'b0;
    end else begin
      rx_sync_ff   <= nxt_rx_sync;
      rx_level_ff  <= nxt_rx_level;
      can_tx_ff    <= nxt_can_tx;
      ack_en_ff    <= nxt_ack_en;
      bg_ff        <= nxt_bg;
      fg_ff        <= nxt_fg;
      txb_ff       <= nxt_txb;
      local_priority_field_ff      <= nxt_local_priority_field;
      rx_full_ff   <= nxt_rx_full;
      bg_full_ff   <= nxt_bg_full;
      ovr_ff       <= nxt_ovr;
      txe_ff       <= nxt_txe;
      abort_acknowledge_bit_ff     <= nxt_abort_acknowledge_bit;
      abrq_ff      <= nxt_abrq;
      txie_ff      <= nxt_txie;
      loop_ff      <= nxt_loop;
      rxie_ff      <= nxt_rxie;
      ovrie_ff     <= nxt_ovrie;
      tx_active_ff <= nxt_tx_active;
      act_idx_ff   <= nxt_act_idx;
      sel_valid_ff <= nxt_sel_valid;
      sel_idx_ff   <= nxt_sel_idx;
      tx_byte_ff   <= nxt_tx_byte;
      rdata_ff     <= nxt_rdata;
      irq_rx_ff    <= nxt_irq_rx;
      irq_tx_ff    <= nxt_irq_tx;
      irq_err_ff   <= nxt_irq_err;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, each from a flop
  assign rdata             = rdata_ff;
  assign can_tx            = can_tx_ff;
  assign irq_rx            = irq_rx_ff;
  assign irq_tx            = irq_tx_ff;
  assign irq_err           = irq_err_ff;
  // engine side travels as one struct, driven by a single assignment
  assign eng_out = cmb_eng_out_type'{
    sel_valid: sel_valid_ff,
    sel_idx:   sel_idx_ff,
    tx_byte:   tx_byte_ff,
    ack_en:    ack_en_ff,
    rx_level:  rx_level_ff
  };
endmodule : cmb_top

/* File: logic/cmb_pkg.sv */
// Contract
// - tx pin low dominant, high recessive
// - two receive stages, only foreground visible
// - each receive buffer holds 13 bytes
// - full flag only for good accepted frame
// - every frame written to background, filter-independent
// - copy to foreground only when full clear
// - background receives right after inter-frame space
// - own frame: background only, no ack
// - loop-back treats own frames as incoming
// - lost arbitration turns node into receiver
// - third accepted frame dropped, overrun flagged
// - both full: transmit on, discard incoming
// - three transmit buffers plus 8-bit priority
// - successful send sets empty, transmit interrupt
// - lowest priority value is sent first
// - selection rerun at every arbitration entry
// - abort granted unless frame is on bus
// - abort acknowledge one if aborted, zero sent
// - write one clears, ignored while condition holds
package cmb_pkg;
  localparam int        NBYTES    = 13;
  localparam int        TX_BUFS   = 3;
  localparam int        AW        = 8;
  localparam logic [3:0] LOCAL_PRIORITY_FIELD_OFS = 4'hD;
  localparam logic [7:0] RFLAG_ADR = 8'h40;
  localparam logic [7:0] TFLAG_ADR = 8'h41;
  localparam logic [7:0] TCTL_ADR  = 8'h42;
  localparam logic [7:0] MCTL_ADR  = 8'h43;
  localparam logic [7:0] TXIE_ADR  = 8'h44;
  localparam int        RF_FULL   = 0;
  localparam int        RF_OVR    = 1;
  localparam int        MC_LOOP   = 0;
  localparam int        MC_RXIE   = 1;
  localparam int        MC_OVRIE  = 2;
  localparam logic      DOMINANT  = 1'b0;
  localparam logic      RECESSIVE = 1'b1;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // byte stream and frame end from the protocol engine
  typedef struct packed {
    logic       wr;
    logic [3:0] idx;
    logic [7:0] data;
    logic       done;
    logic       ok;
    logic       hit;
  } cmb_rx_in_type;

  // arbitration and frame end from the protocol engine
  typedef struct packed {
    logic       arb;
    logic [3:0] rd_idx;
    logic       done;
    logic       fail;
    logic       dom;
  } cmb_tx_in_type;

  // selection, byte fetch and ack control back to the engine
  typedef struct packed {
    logic       sel_valid;
    logic [1:0] sel_idx;
    logic [7:0] tx_byte;
    logic       ack_en;
    logic       rx_level;
  } cmb_eng_out_type;
endpackage : cmb_pkg

/* File: dv/cmb_checker.sv */
`timescale 1ns/1ps
module cmb_checker (
  input wire logic                     clk_sys,
  input wire logic                     nrst,
  input wire logic                     wr,
  input wire logic                     rd,
  input wire logic [7:0]               rdata,
  input wire logic                     can_rx,
  input wire logic                     can_tx,
  input wire cmb_pkg::cmb_rx_in_type   rx_in,
  input wire cmb_pkg::cmb_tx_in_type   tx_in,
  input wire cmb_pkg::cmb_eng_out_type eng_out,
  input wire logic                     irq_rx,
  input wire logic                     irq_tx,
  input wire logic                     irq_err
);
  import cmb_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  property p_tx_pin;
    tx_in.dom |=> can_tx == DOMINANT;
  endproperty
  a_tx_pin: assert property (p_tx_pin) else $error("tx pin not dominant");
  property p_tx_rec;
    !tx_in.dom |=> can_tx == RECESSIVE;
  endproperty
  a_tx_rec: assert property (p_tx_rec) else $error("tx pin not recessive");
  property p_rd_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_rx_irq;
    $rose(irq_rx) |-> $past(rx_in.done && rx_in.ok && rx_in.hit, 2) || $past(wr, 2);
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq without good frame");
  property p_own;
    rx_in.done && !eng_out.ack_en |-> ##2 !$rose(irq_rx);
  endproperty
  a_own: assert property (p_own) else $error("rx irq on own frame");
  property p_ovr;
    $rose(irq_err) |-> $past(rx_in.done && rx_in.ok && rx_in.hit, 2) || $past(wr, 2);
  endproperty
  a_ovr: assert property (p_ovr) else $error("error irq without frame");
  property p_tx_irq;
    $rose(irq_tx) |-> $past(tx_in.done, 2) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4);
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx irq without cause");
  property p_sel_drop;
    (tx_in.done || tx_in.fail) && !tx_in.arb |=> !eng_out.sel_valid;
  endproperty
  a_sel_drop: assert property (p_sel_drop) else $error("selection kept after end");
  property p_lvl_hi;
    can_rx [*6] |-> eng_out.rx_level;
  endproperty
  a_lvl_hi: assert property (p_lvl_hi) else $error("rx level not recessive");
  property p_lvl_lo;
    !can_rx [*6] |-> !eng_out.rx_level;
  endproperty
  a_lvl_lo: assert property (p_lvl_lo) else $error("rx level not dominant");
endmodule : cmb_checker

bind cmb_top cmb_checker u_cmb_checker (
  .clk_sys(clk_sys), .nrst(nrst), .wr(wr), .rd(rd), .rdata(rdata), .can_rx(can_rx),
  .can_tx(can_tx), .rx_in(rx_in), .tx_in(tx_in), .eng_out(eng_out), .irq_rx(irq_rx),
  .irq_tx(irq_tx), .irq_err(irq_err)
);

/* File: dv/cmb_can_model.sv */
`timescale 1ns/1ps
module cmb_can_model (
  input  wire logic                     clk_sys,
  input  wire logic                     can_tx,
  input  wire cmb_pkg::cmb_eng_out_type eng_out,
  output cmb_pkg::cmb_rx_in_type        rx_in,
  output cmb_pkg::cmb_tx_in_type        tx_in,
  output logic                          can_rx
);
  import cmb_pkg::*;
  logic other_dom;
  // wired-and bus, pulled recessive when nobody drives
  assign can_rx = can_tx & ~other_dom;
  // idle engine
  initial begin
    rx_in = '0;
    tx_in = '0;
    other_dom = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one frame into the background stage; end code 1 sends done, 2 fail
  task automatic rx_frame(input logic [7:0] b, input logic ok, input logic hit,
                          input logic [1:0] e);
    for (int i = 0; i < NBYTES; i++) begin
      @(posedge clk_sys);
      rx_in.wr <= 1'b1;
      rx_in.idx <= 4'(i);
      rx_in.data <= b + 8'(i);
      other_dom <= (i > 5);
    end
    @(posedge clk_sys);
    rx_in.wr <= 1'b0;
    rx_in.done <= 1'b1;
    rx_in.ok <= ok;
    rx_in.hit <= hit;
    tx_in.done <= (e == 2'd1);
    tx_in.fail <= (e == 2'd2);
    other_dom <= 1'b0;
    @(posedge clk_sys);
    rx_in.done <= 1'b0;
    tx_in.done <= 1'b0;
    tx_in.fail <= 1'b0;
  endtask : rx_frame
  // arbitration lost: drop out, then take the winner as a plain frame
  task automatic lose_arb(input logic [7:0] b);
    @(posedge clk_sys);
    tx_in.arb <= 1'b1;
    @(posedge clk_sys);
    tx_in.arb <= 1'b0;
    tx_in.fail <= 1'b1;
    @(posedge clk_sys);
    tx_in.fail <= 1'b0;
    rx_frame(b, 1'b1, 1'b1, 2'd0);
  endtask : lose_arb
  // arbitrate, fetch byte 0 and priority, then send or fail with own echo
  task automatic tx_run(input logic ok, output logic [1:0] idx, output logic [7:0] b0,
                        output logic [7:0] pr);
    @(posedge clk_sys);
    tx_in.arb <= 1'b1;
    @(posedge clk_sys);
    tx_in.arb <= 1'b0;
    @(posedge clk_sys);
    idx = eng_out.sel_idx;
    tx_in.rd_idx <= 4'd0;
    tx_in.dom <= 1'b1;
    repeat (2) @(posedge clk_sys);
    b0 = eng_out.tx_byte;
    tx_in.rd_idx <= LOCAL_PRIORITY_FIELD_OFS;
    tx_in.dom <= 1'b0;
    repeat (2) @(posedge clk_sys);
    pr = eng_out.tx_byte;
    rx_frame(b0, ok, 1'b1, ok ? 2'd1 : 2'd2);
  endtask : tx_run
endmodule : cmb_can_model

/* File: dv/cmb_test.sv */
`timescale 1ns/1ps
module cmb_test;
  import cmb_pkg::*;
  logic            clk_sys, nrst, wr, rd, can_rx, can_tx, irq_rx, irq_tx, irq_err;
  logic [7:0]      addr, wdata, rdata, sb0, spr;
  logic [1:0]      sidx;
  cmb_rx_in_type   rx_in;
  cmb_tx_in_type   tx_in;
  cmb_eng_out_type eng_out;
  int              fails, cmp_count;
  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  cmb_top u_cmb_top (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .can_rx(can_rx), .can_tx(can_tx), .rx_in(rx_in), .tx_in(tx_in),
    .eng_out(eng_out), .irq_rx(irq_rx), .irq_tx(irq_tx), .irq_err(irq_err));
  cmb_can_model u_cmb_can_model (.clk_sys(clk_sys), .can_tx(can_tx), .eng_out(eng_out),
    .rx_in(rx_in), .tx_in(tx_in), .can_rx(can_rx));
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    chk(what, rdata, exp);
  endtask : rd_chk
  // verdict and end of run
  task automatic results();
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  // hang guard, about 5000 cycles
  initial begin
    #200000;
    fails++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    chk("tx pin", {7'h00, can_tx}, 8'h01);
    rd_chk("rx flags", RFLAG_ADR, 8'h00);
    rd_chk("tx flags", TFLAG_ADR, 8'h07);
    rd_chk("unmapped", 8'hFF, 8'h00);
    wr_reg(MCTL_ADR, 8'h06);
    u_cmb_can_model.rx_frame(8'h10, 1'b1, 1'b1, 2'd0);
    rd_chk("fg byte0", 8'h00, 8'h10);
    rd_chk("fg byte12", 8'h0C, 8'h1C);
    rd_chk("rx flags", RFLAG_ADR, 8'h01);
    chk("rx irq", {7'h00, irq_rx}, 8'h01);
    u_cmb_can_model.rx_frame(8'h20, 1'b0, 1'b1, 2'd0);
    u_cmb_can_model.rx_frame(8'h30, 1'b1, 1'b0, 2'd0);
    rd_chk("rx flags", RFLAG_ADR, 8'h01);
    rd_chk("fg byte0", 8'h00, 8'h10);
    u_cmb_can_model.rx_frame(8'h40, 1'b1, 1'b1, 2'd0);
    rd_chk("rx flags", RFLAG_ADR, 8'h05);
    u_cmb_can_model.rx_frame(8'h50, 1'b1, 1'b1, 2'd0);
    rd_chk("rx flags", RFLAG_ADR, 8'h07);
    chk("err irq", {7'h00, irq_err}, 8'h01);
    wr_reg(RFLAG_ADR, 8'h03);
    rd_chk("fg byte0", 8'h00, 8'h40);
    rd_chk("rx flags", RFLAG_ADR, 8'h01);
    wr_reg(RFLAG_ADR, 8'h01);
    rd_chk("rx flags", RFLAG_ADR, 8'h00);
    // transmit side: priorities 5, 5, 2
    wr_reg(8'h1D, 8'h05);
    wr_reg(8'h2D, 8'h05);
    wr_reg(8'h3D, 8'h02);
    wr_reg(8'h10, 8'hA5);
    wr_reg(TXIE_ADR, 8'h07);
    wr_reg(TFLAG_ADR, 8'h07);
    rd_chk("tx flags", TFLAG_ADR, 8'h00);
    fork
      u_cmb_can_model.tx_run(1'b1, sidx, sb0, spr);
      begin
        repeat (4) @(negedge clk_sys);
        chk("ack off", {7'h00, eng_out.ack_en}, 8'h00);
        chk("sel valid", {7'h00, eng_out.sel_valid}, 8'h01);
      end
    join
    chk("sel", {6'h00, sidx}, 8'h02);
    chk("local_priority_field", spr, 8'h02);
    rd_chk("tx flags", TFLAG_ADR, 8'h04);
    rd_chk("rx flags", RFLAG_ADR, 8'h00);
    rd_chk("fg byte0", 8'h00, 8'h40);
    chk("tx irq", {7'h00, irq_tx}, 8'h01);
    u_cmb_can_model.tx_run(1'b0, sidx, sb0, spr);
    chk("sel", {6'h00, sidx}, 8'h00);
    chk("byte0", sb0, 8'hA5);
    wr_reg(8'h2D, 8'h01);
    u_cmb_can_model.tx_run(1'b0, sidx, sb0, spr);
    chk("sel", {6'h00, sidx}, 8'h01);
    u_cmb_can_model.lose_arb(8'h60);
    rd_chk("rx flags", RFLAG_ADR, 8'h01);
    rd_chk("fg byte0", 8'h00, 8'h60);
    wr_reg(RFLAG_ADR, 8'h01);
    wr_reg(TCTL_ADR, 8'h02);
    rd_chk("tx flags", TFLAG_ADR, 8'h26);
    fork
      u_cmb_can_model.tx_run(1'b1, sidx, sb0, spr);
      wr_reg(TCTL_ADR, 8'h01);
    join
    rd_chk("tx flags", TFLAG_ADR, 8'h27);
    wr_reg(MCTL_ADR, 8'h07);
    wr_reg(TFLAG_ADR, 8'h04);
    fork
      u_cmb_can_model.tx_run(1'b1, sidx, sb0, spr);
      begin
        repeat (4) @(negedge clk_sys);
        chk("ack on", {7'h00, eng_out.ack_en}, 8'h01);
      end
    join
    rd_chk("rx flags", RFLAG_ADR, 8'h01);
    rd_chk("fg byte1", 8'h01, 8'h01);
    chk("rx irq", {7'h00, irq_rx}, 8'h01);
    results();
  end
endmodule : cmb_test
